// File: verilog/dce_top.sv
/*
  dce_top: control registers, flags and shared interrupt for two
  comparators. Assumes comparator results and timer overflows arrive as
  inputs; overflows are mclk-domain pulses, results are asynchronous.
*/
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: result is one only when positive input exceeds negative input.
// R2: each comparator runs only while its enable bit 3 is set.
// R3: inputs connect only while connect bit 5 set; software sets it first.
// R4: software holds interrupt off 10 us after enable, clears flag first.
// R5: condition field picks level, edge or toggle; match sets flag.
// R6: flags stay set until cleared; pollable and can interrupt.
// R7: both comparators share one interrupt; flags tell the source.
// R8: sample source field picks every clock or timer 0/1/2 overflow.
// R9: work in idle, forced off in power-down regardless of enable.
// R10: channel field routes one of four analog pins to positive input.
// R11: software disconnects before changing channel or reference.
// R12: reference field picks nominal, 100 mV above or below level.
// R13: three debounce modes apply to edge conditions only.
// R14: debounce waits two timer 1 overflows, resamples, drops mismatch.
// R15: timer sampled edge must persist four samples to count.
// R16: comparator outputs pass two flip-flops before any evaluation.
// R17: writing zero clears a flag, one keeps it; set beats clear.
module dce_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] cmp_result,
  input wire dce_pkg::dce_ovf_t timer_ovf,
  input wire logic power_down,
  output logic [1:0] cmp_power,
  output logic [1:0] cmp_a_connect,
  output logic [1:0] cmp_a_channel_select,
  output logic [1:0] cmp_a_reference_select,
  output logic [1:0] cmp_b_connect,
  output logic [1:0] cmp_b_channel_select,
  output logic [1:0] cmp_b_reference_select,
  output logic cmp_irq
);

  logic [7:0] cmp_a_control_status;
  logic [7:0] cmp_b_control_status;
  logic [7:0] cmp_reference_control;
  logic [1:0] cmp_event_flag;
  logic [1:0] cmp_interrupt_enable;
  logic [1:0] hit;
  logic [1:0] sync_out;
  logic [1:0] active;
  logic [1:0] ena;
  logic [1:0] con;
  logic [1:0] flag_clr;
  logic [1:0] next_flag;
  logic [1:0] flag_w1c;
  logic [1:0] flag_w0c;
  logic wr_a;
  logic wr_b;
  logic wr_ref;
  logic wr_stat;
  logic wr_mask;
  logic [7:0] rd_mux;
  dce_pkg::dce_cfg_t cfg_a;
  dce_pkg::dce_cfg_t cfg_b;

  // address decode
  assign wr_a = reg_wr & (reg_addr == dce_pkg::OFF_CTRL_A);
  assign wr_b = reg_wr & (reg_addr == dce_pkg::OFF_CTRL_B);
  assign wr_ref = reg_wr & (reg_addr == dce_pkg::OFF_REF);
  assign wr_stat = reg_wr & (reg_addr == dce_pkg::OFF_STATUS);
  assign wr_mask = reg_wr & (reg_addr == dce_pkg::OFF_MASK);

  // enable and connect; power-down overrides, idle does not
  assign ena[0] = cmp_a_control_status[dce_pkg::CTL_ENABLE]; // R2
  assign ena[1] = cmp_b_control_status[dce_pkg::CTL_ENABLE]; // R2
  assign con[0] = cmp_a_control_status[dce_pkg::CTL_CONNECT];
  assign con[1] = cmp_b_control_status[dce_pkg::CTL_CONNECT];
  assign active = ena & con & {2{!power_down}}; // R2 R3 R9
  assign cmp_power = ena & {2{!power_down}}; // R9
  assign cmp_a_connect = {1'b0, con[0] & !power_down}; // R3
  assign cmp_b_connect = {1'b0, con[1] & !power_down}; // R3

  // analog routing selects straight from the registers
  assign cmp_a_channel_select =
    cmp_a_control_status[dce_pkg::CTL_CHAN_LSB +: 2]; // R10
  assign cmp_b_channel_select =
    cmp_b_control_status[dce_pkg::CTL_CHAN_LSB +: 2]; // R10
  assign cmp_a_reference_select =
    cmp_reference_control[dce_pkg::REF_A_LSB +: 2]; // R12
  assign cmp_b_reference_select =
    cmp_reference_control[dce_pkg::REF_B_LSB +: 2]; // R12

  // configuration bundles for the channel logic
  assign cfg_a.chan = cmp_a_channel_select;
  assign cfg_a.connect = con[0];
  assign cfg_a.enable = ena[0];
  assign cfg_a.cond = dce_pkg::dce_cond_t'(
    cmp_a_control_status[dce_pkg::CTL_COND_LSB +: 3]); // R5
  assign cfg_a.src = dce_pkg::dce_src_t'(
    cmp_reference_control[dce_pkg::SRC_A_LSB +: 2]); // R8
  assign cfg_a.refsel = cmp_a_reference_select;
  assign cfg_b.chan = cmp_b_channel_select;
  assign cfg_b.connect = con[1];
  assign cfg_b.enable = ena[1];
  assign cfg_b.cond = dce_pkg::dce_cond_t'(
    cmp_b_control_status[dce_pkg::CTL_COND_LSB +: 3]); // R5
  assign cfg_b.src = dce_pkg::dce_src_t'(
    cmp_reference_control[dce_pkg::SRC_B_LSB +: 2]); // R8
  assign cfg_b.refsel = cmp_b_reference_select;

  dce_channel u_cmp_a (
    .mclk(mclk),
    .nrst(nrst),
    .cmp_raw(cmp_result[0]),
    .active(active[0]),
    .cfg(cfg_a),
    .ovf(timer_ovf),
    .cmp_sync(sync_out[0]),
    .hit(hit[0])
  );

  dce_channel u_cmp_b (
    .mclk(mclk),
    .nrst(nrst),
    .cmp_raw(cmp_result[1]),
    .active(active[1]),
    .cfg(cfg_b),
    .ovf(timer_ovf),
    .cmp_sync(sync_out[1]),
    .hit(hit[1])
  );

  // flag clears: zero in a control register flag bit, or one in status
  assign flag_w0c[0] = wr_a & !reg_wdata[dce_pkg::CTL_FLAG]; // R17
  assign flag_w0c[1] = wr_b & !reg_wdata[dce_pkg::CTL_FLAG]; // R17
  assign flag_w1c = {2{wr_stat}} & reg_wdata[1:0];
  assign flag_clr = flag_w0c | flag_w1c;
  // set wins over a same-cycle clear so no event is lost
  assign next_flag = (cmp_event_flag & ~flag_clr) | hit; // R6 R17

  // configuration registers; flag bit stored separately
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmp_a_control_status <= dce_pkg::CTRL_RST;
      cmp_b_control_status <= dce_pkg::CTRL_RST;
      cmp_reference_control <= dce_pkg::REF_RST;
      cmp_interrupt_enable <= dce_pkg::MASK_RST;
    end else begin
      if (wr_a) begin
        cmp_a_control_status <= reg_wdata;
      end
      if (wr_b) begin
        cmp_b_control_status <= reg_wdata;
      end
      if (wr_ref) begin
        cmp_reference_control <= reg_wdata;
      end
      if (wr_mask) begin
        cmp_interrupt_enable <= reg_wdata[1:0];
      end
    end
  end

  // sticky event flags
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmp_event_flag <= 2'h0;
    end else begin
      cmp_event_flag <= next_flag; // R6
    end
  end

  // one shared level interrupt for both comparators
  assign cmp_irq = |(cmp_event_flag & cmp_interrupt_enable); // R7

  // read mux; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      dce_pkg::OFF_CTRL_A: rd_mux = {cmp_a_control_status[7:5],
        cmp_event_flag[0], cmp_a_control_status[3:0]};
      dce_pkg::OFF_CTRL_B: rd_mux = {cmp_b_control_status[7:5],
        cmp_event_flag[1], cmp_b_control_status[3:0]};
      dce_pkg::OFF_REF: rd_mux = cmp_reference_control;
      dce_pkg::OFF_STATUS: rd_mux = {6'h00, cmp_event_flag};
      dce_pkg::OFF_MASK: rd_mux = {6'h00, cmp_interrupt_enable};
      dce_pkg::OFF_STATE: rd_mux = {4'h0, active, sync_out}; // R1
      default: rd_mux = 8'h00;
    endcase
  end

  // read data registered, valid only the cycle after the strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  property p_flag_sticky;
    @(posedge mclk) disable iff (!nrst)
      (cmp_event_flag[0] && !flag_clr[0]) |=> cmp_event_flag[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // R6
    else $error("flag a dropped without clear");

  property p_set_wins;
    @(posedge mclk) disable iff (!nrst)
      (hit[1] && flag_clr[1]) |=> cmp_event_flag[1];
  endproperty
  a_set_wins: assert property (p_set_wins) // R17
    else $error("set lost against clear");

  property p_irq;
    @(posedge mclk) disable iff (!nrst)
      (|(hit & cmp_interrupt_enable) && !wr_mask) |=> cmp_irq;
  endproperty
  a_irq: assert property (p_irq) // R7
    else $error("irq does not follow masked flags");

  property p_pd_off;
    @(posedge mclk) disable iff (!nrst)
      power_down |-> (cmp_power == 2'h0) && (active == 2'h0);
  endproperty
  a_pd_off: assert property (p_pd_off) // R9
    else $error("comparator on during power-down");

  property p_no_hit_inactive;
    @(posedge mclk) disable iff (!nrst)
      !active[0] |-> !hit[0];
  endproperty
  a_no_hit_inactive: assert property (p_no_hit_inactive) // R2
    else $error("hit on inactive comparator a");

  property p_wr_clear;
    @(posedge mclk) disable iff (!nrst)
      (flag_w0c[0] && !hit[0]) |=> !cmp_event_flag[0];
  endproperty
  a_wr_clear: assert property (p_wr_clear) // R17
    else $error("zero write did not clear flag");

  sequence s_read;
    reg_rd && reg_addr == dce_pkg::OFF_STATUS;
  endsequence
  property p_read_status;
    @(posedge mclk) disable iff (!nrst)
      s_read |=> reg_rdata[1:0] == $past(cmp_event_flag);
  endproperty
  a_read_status: assert property (p_read_status) // R6
    else $error("status read wrong");

  property p_chan;
    @(posedge mclk) disable iff (!nrst)
      wr_a |=> cmp_a_channel_select == $past(reg_wdata[7:6]);
  endproperty
  a_chan: assert property (p_chan) // R10
    else $error("channel select not updated");

  // an unpowered or loose comparator must never report an event
  property p_no_hit_inactive_b;
    @(posedge mclk) disable iff (!nrst)
      !active[1] |-> !hit[1];
  endproperty
  a_no_hit_inactive_b: assert property (p_no_hit_inactive_b) // R2
    else $error("hit on inactive comparator b");

  property p_disconnect;
    @(posedge mclk) disable iff (!nrst)
      (wr_a && !reg_wdata[dce_pkg::CTL_CONNECT]) |=> !active[0];
  endproperty
  a_disconnect: assert property (p_disconnect) // R3
    else $error("comparator a still active after disconnect");

  // result seen two edges late, zero while inactive
  property p_sync_a;
    @(posedge mclk) disable iff (!nrst)
      sync_out[0] == ($past(cmp_result[0], 2) & $past(active[0]));
  endproperty
  a_sync_a: assert property (p_sync_a) // R16
    else $error("comparator a sync path wrong");

  property p_sync_b;
    @(posedge mclk) disable iff (!nrst)
      sync_out[1] == ($past(cmp_result[1], 2) & $past(active[1]));
  endproperty
  a_sync_b: assert property (p_sync_b) // R16
    else $error("comparator b sync path wrong");

  sequence s_high_a;
    active[0] && sync_out[0] && cfg_a.cond == dce_pkg::DCE_COND_HIGH &&
      cfg_a.src == dce_pkg::DCE_SRC_CLK;
  endsequence
  property p_high_a;
    @(posedge mclk) disable iff (!nrst)
      s_high_a |-> hit[0];
  endproperty
  a_high_a: assert property (p_high_a) // R5
    else $error("high level missed on comparator a");

  // timer sampled edges may only land on the chosen overflow
  property p_t2_strobe;
    @(posedge mclk) disable iff (!nrst)
      (hit[0] && cfg_a.src == dce_pkg::DCE_SRC_T2 &&
        cfg_a.cond == dce_pkg::DCE_COND_RISE) |-> timer_ovf.t2;
  endproperty
  a_t2_strobe: assert property (p_t2_strobe) // R8
    else $error("timer 2 sampled hit off its overflow");

  property p_db_t1;
    @(posedge mclk) disable iff (!nrst)
      (hit[0] && cfg_a.cond == dce_pkg::DCE_COND_RISE_DB) |-> timer_ovf.t1;
  endproperty
  a_db_t1: assert property (p_db_t1) // R14
    else $error("debounced hit off a timer 1 overflow");

  property p_w1c;
    @(posedge mclk) disable iff (!nrst)
      (wr_stat && reg_wdata[0] && !hit[0]) |=> !cmp_event_flag[0];
  endproperty
  a_w1c: assert property (p_w1c) // R17
    else $error("status write did not clear flag a");

  sequence s_read_ctrl_b;
    reg_rd && reg_addr == dce_pkg::OFF_CTRL_B;
  endsequence
  property p_read_ctrl_b;
    @(posedge mclk) disable iff (!nrst)
      s_read_ctrl_b |=>
        reg_rdata[dce_pkg::CTL_FLAG] == $past(cmp_event_flag[1]);
  endproperty
  a_read_ctrl_b: assert property (p_read_ctrl_b) // R6
    else $error("control b read shows wrong flag");

  // read data stands one cycle only, then the bus reads zero
  property p_rdata_idle;
    @(posedge mclk) disable iff (!nrst)
      !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // R6
    else $error("read data held past its cycle");

  property p_ref_b;
    @(posedge mclk) disable iff (!nrst)
      wr_ref |=>
        cmp_b_reference_select == $past(reg_wdata[dce_pkg::REF_B_LSB +: 2]);
  endproperty
  a_ref_b: assert property (p_ref_b) // R12
    else $error("reference select b not updated");

endmodule
`default_nettype wire

// File: verilog/dce_pkg.sv
/*
  dce_pkg: constants, register map and types for the dual comparator
  event logic. Assumes a plain register port with byte-wide data.
*/
`default_nettype none
package dce_pkg;

  // register offsets (byte port, one register per address)
  localparam logic [2:0] OFF_CTRL_A = 3'h0;
  localparam logic [2:0] OFF_CTRL_B = 3'h1;
  localparam logic [2:0] OFF_REF = 3'h2;
  localparam logic [2:0] OFF_STATUS = 3'h3;
  localparam logic [2:0] OFF_MASK = 3'h4;
  localparam logic [2:0] OFF_STATE = 3'h5;

  // control register field positions
  localparam int CTL_COND_LSB = 0;
  localparam int CTL_ENABLE = 3;
  localparam int CTL_FLAG = 4;
  localparam int CTL_CONNECT = 5;
  localparam int CTL_CHAN_LSB = 6;

  // reference register field positions
  localparam int REF_A_LSB = 0;
  localparam int REF_B_LSB = 2;
  localparam int SRC_A_LSB = 4;
  localparam int SRC_B_LSB = 6;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] REF_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;

  // debounce timing
  localparam int DEB_OVF_COUNT = 2;
  localparam int PERSIST_SAMPLES = 4;

  // interrupt condition encodings
  typedef enum logic [2:0] {
    DCE_COND_LOW = 3'h0,
    DCE_COND_HIGH = 3'h1,
    DCE_COND_TOGGLE = 3'h2,
    DCE_COND_RISE = 3'h4,
    DCE_COND_FALL = 3'h5,
    DCE_COND_RISE_DB = 3'h6,
    DCE_COND_FALL_DB = 3'h7,
    DCE_COND_TOGGLE_DB = 3'h3
  } dce_cond_t;

  // sampling sources
  typedef enum logic [1:0] {
    DCE_SRC_CLK = 2'h0,
    DCE_SRC_T0 = 2'h1,
    DCE_SRC_T1 = 2'h2,
    DCE_SRC_T2 = 2'h3
  } dce_src_t;

  // per comparator configuration
  typedef struct packed {
    logic [1:0] chan;
    logic connect;
    logic enable;
    dce_cond_t cond;
    dce_src_t src;
    logic [1:0] refsel;
  } dce_cfg_t;

  // timer overflow pulses
  typedef struct packed {
    logic t2;
    logic t1;
    logic t0;
  } dce_ovf_t;

endpackage
`default_nettype wire

// File: verilog/dce_channel.sv
/*
  dce_channel: synchroniser, sampling, condition match and debounce for
  one comparator. Assumes overflow pulses are one mclk cycle wide.
*/
`timescale 1ns/1ps
`default_nettype none
module dce_channel (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cmp_raw,
  input wire logic active,
  input wire dce_pkg::dce_cfg_t cfg,
  input wire dce_pkg::dce_ovf_t ovf,
  output logic cmp_sync,
  output logic hit
);

  logic sync1;
  logic sample;
  logic have_sample;
  logic [2:0] persist_cnt;
  logic db_wait;
  logic db_expect;
  logic [1:0] db_ovf;
  logic [1:0] cond_lo;
  logic is_edge;
  logic debounce;
  logic sample_en;
  logic cand;
  logic rise;
  logic fall;
  logic want;
  logic accept;
  logic db_done;
  logic timed;

  // two stage synchroniser on the analog result
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      sync1 <= cmp_raw; // R16
      cmp_sync <= sync1 & active; // R1 R16
    end
  end

  // sample strobe selection
  assign sample_en = (cfg.src == dce_pkg::DCE_SRC_CLK) ? 1'b1 :
                     (cfg.src == dce_pkg::DCE_SRC_T0) ? ovf.t0 :
                     (cfg.src == dce_pkg::DCE_SRC_T1) ? ovf.t1 :
                     ovf.t2; // R8
  assign timed = (cfg.src != dce_pkg::DCE_SRC_CLK);
  assign cond_lo = cfg.cond[1:0];
  assign debounce = (cfg.cond == dce_pkg::DCE_COND_RISE_DB) |
                    (cfg.cond == dce_pkg::DCE_COND_FALL_DB) |
                    (cfg.cond == dce_pkg::DCE_COND_TOGGLE_DB); // R13
  assign is_edge = cfg.cond[2] | (cfg.cond == dce_pkg::DCE_COND_TOGGLE)
                   | debounce;

  // candidate transition of the sampled output
  assign cand = active & sample_en & have_sample & (cmp_sync != sample);
  assign rise = cand & cmp_sync;
  assign fall = cand & !cmp_sync;
  // persistence of four timer samples before an edge counts
  assign accept = !timed |
    (persist_cnt == 3'(dce_pkg::PERSIST_SAMPLES - 1)); // R15
  assign want = (cfg.cond == dce_pkg::DCE_COND_RISE ||
                 cfg.cond == dce_pkg::DCE_COND_RISE_DB) ? rise :
                (cfg.cond == dce_pkg::DCE_COND_FALL ||
                 cfg.cond == dce_pkg::DCE_COND_FALL_DB) ? fall :
                (rise | fall);
  assign db_done = db_wait & ovf.t1 &
    (db_ovf == 2'(dce_pkg::DEB_OVF_COUNT - 1)); // R14

  // condition match: level, edge, or debounced edge
  always_comb begin
    hit = 1'b0;
    if (active && !is_edge && sample_en) begin
      hit = (cond_lo == 2'h1) ? cmp_sync : !cmp_sync; // R5
    end else if (active && is_edge && !debounce) begin
      hit = want & accept; // R5
    end else if (active && debounce) begin
      hit = db_done & (cmp_sync == db_expect); // R14
    end
  end

  // held sample and persistence counter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sample <= 1'b0;
      have_sample <= 1'b0;
      persist_cnt <= 3'h0;
    end else if (!active) begin
      have_sample <= 1'b0;
      persist_cnt <= 3'h0;
    end else if (sample_en) begin
      have_sample <= 1'b1;
      if (!have_sample || cmp_sync == sample || accept) begin
        sample <= cmp_sync;
        persist_cnt <= 3'h0;
      end else begin
        persist_cnt <= persist_cnt + 3'h1; // R15
      end
    end
  end

  // debounce wait: two timer 1 overflows then resample
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      db_wait <= 1'b0;
      db_expect <= 1'b0;
      db_ovf <= 2'h0;
    end else if (!active || !debounce) begin
      db_wait <= 1'b0;
      db_ovf <= 2'h0;
    end else if (!db_wait && want && accept) begin
      db_wait <= 1'b1; // R14
      db_expect <= cmp_sync;
      db_ovf <= 2'h0;
    end else if (db_done) begin
      db_wait <= 1'b0; // mismatch simply drops the event
      db_ovf <= 2'h0;
    end else if (db_wait && ovf.t1) begin
      db_ovf <= db_ovf + 2'h1;
    end
  end

endmodule
`default_nettype wire

// File: tb/dce_analog_model.sv
/*
  dce_analog_model: two comparator front ends and three free running
  timers. Assumes the bench says which positive inputs are above.
*/
`timescale 1ns/1ps
`default_nettype none
module dce_analog_model #(
  parameter int P0 = 8,
  parameter int P1 = 8,
  parameter int P2 = 12
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [1:0] above,
  input wire logic [1:0] power,
  input wire logic [1:0] conn,
  output logic [1:0] cmp_result,
  output dce_pkg::dce_ovf_t timer_ovf
);
  logic tog;
  logic [1:0] live;
  int c0, c1, c2;
  // an unpowered or loose front end gives junk, so the block must gate it
  assign live = power & conn;
  assign cmp_result = (live & above) | (~live & {tog, ~tog});
  // one-cycle overflows, phases apart so no two timers line up
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      c0 <= 0;
      c1 <= 3;
      c2 <= 5;
      tog <= 1'b0;
      timer_ovf <= '0;
    end else begin
      tog <= ~tog;
      c0 <= (c0 == P0 - 1) ? 0 : c0 + 1;
      c1 <= (c1 == P1 - 1) ? 0 : c1 + 1;
      c2 <= (c2 == P2 - 1) ? 0 : c2 + 1;
      timer_ovf.t0 <= (c0 == P0 - 1);
      timer_ovf.t1 <= (c1 == P1 - 1);
      timer_ovf.t2 <= (c2 == P2 - 1);
    end
  end
endmodule
`default_nettype wire

// File: tb/dual_comparator_event_logic_tb.sv
/*
  dual_comparator_event_logic_tb: scenario tasks for the comparator
  event logic. Assumes the front end model beside it supplies results
  and timer overflows.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module dual_comparator_event_logic_tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic power_down = 1'b0;
  logic [1:0] above = 2'h0;
  logic [7:0] reg_rdata;
  logic [1:0] cmp_result, cmp_power, a_con, a_ch, a_rf, b_con, b_ch, b_rf;
  logic cmp_irq;
  dce_pkg::dce_ovf_t timer_ovf;
  int mismatches = 0;
  int n_compared = 0;
  logic [2:0] cd [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
  logic [2:0] ex [5] = '{3'h7, 3'h3, 3'h3, 3'h2, 3'h1};

  always #5 mclk = ~mclk;

  dce_top u_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmp_result(cmp_result), .timer_ovf(timer_ovf),
    .power_down(power_down), .cmp_power(cmp_power), .cmp_a_connect(a_con),
    .cmp_a_channel_select(a_ch), .cmp_a_reference_select(a_rf),
    .cmp_b_connect(b_con), .cmp_b_channel_select(b_ch),
    .cmp_b_reference_select(b_rf), .cmp_irq(cmp_irq));

  dce_analog_model u_fe (.mclk(mclk), .nrst(nrst), .above(above),
    .power(cmp_power), .conn({b_con[0], a_con[0]}),
    .cmp_result(cmp_result), .timer_ovf(timer_ovf));

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  task automatic t_reset;
    for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
    `CHK(cmp_irq, 1'b0)
  endtask

  task automatic t_gate;
    wr(dce_pkg::OFF_CTRL_A, 8'h38);
    wr(dce_pkg::OFF_CTRL_A, 8'h18);
    wr(dce_pkg::OFF_CTRL_A, 8'h98);
    wr(dce_pkg::OFF_CTRL_A, 8'hb8);
    wr(dce_pkg::OFF_REF, 8'h09);
    #1;
    `CHK(cmp_power, 2'h1)
    `CHK(a_con, 2'h1)
    `CHK(a_ch, 2'h2)
    `CHK(a_rf, 2'h1)
    `CHK(b_rf, 2'h2)
    cyc(1);
    above <= 2'h3;
    wr(dce_pkg::OFF_CTRL_B, 8'hc8);
    cyc(6);
    #1;
    `CHK(cmp_power, 2'h3)
    `CHK(b_con, 2'h0)
    `CHK(b_ch, 2'h3)
    rd(dce_pkg::OFF_STATE, 8'h05);
    cyc(1);
    power_down <= 1'b1;
    cyc(4);
    #1;
    `CHK(cmp_power, 2'h0)
    rd(dce_pkg::OFF_STATE, 8'h00);
    cyc(1);
    power_down <= 1'b0;
    wr(dce_pkg::OFF_CTRL_B, 8'h00);
  endtask

  // each non-debounced condition over three phases: low, rising, cleared then falling
  task automatic t_cond;
    for (int i = 0; i < 5; i++) begin
      cyc(1);
      above <= 2'h0;
      wr(dce_pkg::OFF_REF, 8'h00);
      wr(dce_pkg::OFF_CTRL_A, 8'h38 | cd[i]);
      cyc(6);
      wr(dce_pkg::OFF_STATUS, 8'h03);
      cyc(6);
      rd(dce_pkg::OFF_STATUS, {7'h0, ex[i][2]});
      cyc(1);
      above <= 2'h1;
      cyc(8);
      rd(dce_pkg::OFF_STATUS, {7'h0, ex[i][1]});
      wr(dce_pkg::OFF_STATUS, 8'h03);
      above <= 2'h0;
      cyc(8);
      rd(dce_pkg::OFF_STATUS, {7'h0, ex[i][0]});
    end
  endtask

  // edge with optional two-cycle glitch, sampled every clock
  task automatic t_deb(input logic [2:0] c, input logic st, input logic gl,
                       input logic e);
    cyc(1);
    above <= {1'b0, st};
    wr(dce_pkg::OFF_REF, 8'h00);
    wr(dce_pkg::OFF_CTRL_A, 8'h38 | c);
    cyc(8);
    wr(dce_pkg::OFF_STATUS, 8'h03);
    above <= {1'b0, ~st};
    if (gl) begin
      cyc(2);
      above <= {1'b0, st};
    end
    cyc(40);
    rd(dce_pkg::OFF_STATUS, {7'h0, e});
  endtask

  // rising edge sampled by a timer, held for hold cycles
  task automatic t_per(input logic [1:0] src, input int hold, input logic e);
    cyc(1);
    above <= 2'h0;
    wr(dce_pkg::OFF_REF, {2'h0, src, 4'h0});
    wr(dce_pkg::OFF_CTRL_A, 8'h3c);
    cyc(8);
    wr(dce_pkg::OFF_STATUS, 8'h03);
    above <= 2'h1;
    cyc(hold);
    above <= 2'h0;
    cyc(80);
    rd(dce_pkg::OFF_STATUS, {7'h0, e});
  endtask

  task automatic t_irq;
    cyc(1);
    above <= 2'h3;
    wr(dce_pkg::OFF_REF, 8'h00);
    wr(dce_pkg::OFF_MASK, 8'h00);
    wr(dce_pkg::OFF_CTRL_A, 8'h39);
    wr(dce_pkg::OFF_CTRL_B, 8'h39);
    cyc(6);
    #1;
    `CHK(cmp_irq, 1'b0)
    rd(dce_pkg::OFF_STATUS, 8'h03);
    wr(dce_pkg::OFF_MASK, 8'h01);
    #1;
    `CHK(cmp_irq, 1'b1)
    wr(dce_pkg::OFF_CTRL_A, 8'h3c);
    wr(dce_pkg::OFF_STATUS, 8'h01);
    rd(dce_pkg::OFF_STATUS, 8'h02);
    `CHK(cmp_irq, 1'b0)
    wr(dce_pkg::OFF_MASK, 8'h02);
    #1;
    `CHK(cmp_irq, 1'b1)
    wr(dce_pkg::OFF_STATUS, 8'h02);
    rd(dce_pkg::OFF_STATUS, 8'h02);
    wr(dce_pkg::OFF_CTRL_B, 8'h3c);
    rd(dce_pkg::OFF_CTRL_B, 8'h3c);
    wr(dce_pkg::OFF_CTRL_B, 8'h2c);
    rd(dce_pkg::OFF_CTRL_B, 8'h2c);
    rd(dce_pkg::OFF_STATUS, 8'h00);
    `CHK(cmp_irq, 1'b0)
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // about eleven hundred cycles are expected; far beyond that is a hang
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_gate();
    t_cond();
    t_deb(3'h6, 1'b0, 1'b1, 1'b0);
    t_deb(3'h6, 1'b0, 1'b0, 1'b1);
    t_deb(3'h7, 1'b1, 1'b1, 1'b0);
    t_deb(3'h7, 1'b1, 1'b0, 1'b1);
    t_deb(3'h3, 1'b0, 1'b0, 1'b1);
    t_deb(3'h4, 1'b0, 1'b1, 1'b1);
    t_per(2'h1, 12, 1'b0);
    t_per(2'h3, 80, 1'b1);
    t_per(2'h2, 80, 1'b1);
    t_irq();
    report_and_stop();
  end
endmodule
`default_nettype wire
